/* rtl/acb_consts.svh */
// Purpose: Offsets, field positions, reset values and counts for the channel buffer control
// Assumes: 32-bit Avalon-MM word addressing by byte address
// Notes: Definitions only
`ifndef ACB_CONSTS_SVH
`define ACB_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ACB_OFF_CTRL2 6'h00
`define ACB_OFF_CTRL3 6'h04
`define ACB_OFF_CTRL4 6'h08
`define ACB_OFF_CHS123 6'h0c
`define ACB_OFF_CHS0 6'h10
`define ACB_OFF_SCAN 6'h14
`define ACB_OFF_PIN_CONFIG_BITS 6'h18
`define ACB_OFF_MODE 6'h1c

// ****************************************
// Write masks (implemented bits)
// ****************************************
`define ACB_MASK_CTRL2 16'h073f
`define ACB_MASK_CTRL3 16'h9fff
`define ACB_MASK_CTRL4 16'h0007
`define ACB_MASK_CHS123 16'h0707
`define ACB_MASK_CHS0 16'h9f9f
`define ACB_MASK_SCAN 16'h1fff
`define ACB_MASK_PIN_CONFIG_BITS 16'h1fff
`define ACB_MASK_MODE 16'h001f
`define ACB_RESET_VAL 16'h0000

// ****************************************
// Field positions
// ****************************************
`define ACB_C2_SCAN_EN 10
`define ACB_C2_CHUSED_HI 9
`define ACB_C2_CHUSED_LO 8
`define ACB_C2_HALF 7
`define ACB_C2_RATE_HI 5
`define ACB_C2_RATE_LO 2
`define ACB_C2_SPLIT 1
`define ACB_C2_ALT 0
`define ACB_C3_RC 15
`define ACB_C3_SAMT_HI 12
`define ACB_C3_SAMT_LO 8
`define ACB_C3_DIV_HI 7
`define ACB_C3_DIV_LO 0
`define ACB_MD_RES 0
`define ACB_MD_TRIG_HI 3
`define ACB_MD_TRIG_LO 1
`define ACB_MD_DISABLE 4

// ****************************************
// Codes and counts
// ****************************************
`define ACB_TRIG_AUTO 3'h7
`define ACB_DIV_MAX 8'h3f
`define ACB_HALF_UPPER 4'h8
`define ACB_HALF_LOWER 4'h0
`define ACB_NUM_INPUTS 13
`define ACB_POS_MAX 5'h0c

`endif

/* rtl/acb_pkg.sv */
// Purpose: Types shared by the channel buffer control
// Assumes: Constants come from acb_consts.svh
// Notes: Types only
package acb_pkg;

   // ****************************************
   // Multiplexer selection bundle
   // ****************************************
   typedef struct packed {
      logic [4:0] zero_pos;
      logic zero_pos_vref_neg;
      logic zero_neg;
      logic ch_1_3_pos;
      logic [1:0] ch_1_3_neg;
      logic [1:0] channels_used;
      logic sample_b;
   } acb_sel_t;

   // ****************************************
   // Buffer and timing bundle
   // ****************************************
   typedef struct packed {
      logic [3:0] start_addr;
      logic [7:0] words_per_input;
      logic [4:0] auto_sample_time;
      logic auto_sample_on;
   } acb_buf_t;

endpackage

/* rtl/acb_channel_buffer_control.sv */
// Purpose: Sequencer control for the converter: muxes, scan, buffer fill, clocking
// Assumes: conv_done comes from converter logic on clk; rc_clock_in is asynchronous
// Notes: Avalon-MM slave, one wait state on every access
//
// Contract
// - Scan enable steps channel 0 Sample A
// - Channels-used picks set; zero in 12-bit
// - Half status shows upper half filling
// - Advance every (rate+1)th conversion
// - Split mode alternates start 0x0/0x8
// - Alternate mode swaps A and B selections
// - Clock source picks RC or system
// - Auto sample time only with code 111
// - Divider gives period (field+1) cycles
// - Buffer words per input are 2^code
// - Channels 1-3 negative select decoding
// - Channels 1-3 positive select decoding
// - Channels 1-3 selects zero in 12-bit
// - Channel 0 positive selects ANn directly
// - Channel 0 negative: AN1 or reference
// - Scan list bit includes its input
// - Missing pin input converts negative reference
// - Pin config bit sets digital, grounds mux
// - Module disable forces all pins digital
// - Resolution bit selects 12 or 10 bit; not output here, only zeroes channels-used and channels 1-3
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "acb_consts.svh"

module acb_channel_buffer_control
   import acb_pkg::*;
#(
   parameter logic [12:0] PIN_PRESENT = 13'h1fff
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Avalon-MM slave
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   // Converter side
   input wire logic conv_done,
   input wire logic rc_clock_in,
   output logic conv_clk_tick,
   output acb_sel_t sel,
   output acb_buf_t buf_cfg,
   output logic dma_advance,
   // Pins
   output logic [12:0] pin_digital,
   output logic [12:0] mux_ground
);

   // ****************************************
   // Functions
   // ****************************************
   // Lowest listed input at or above start, wrapping to the lowest one
   function automatic logic [3:0] scan_pick(input logic [12:0] list, input logic [4:0] start);
      logic [3:0] hit;
      logic found;
      hit = 4'h0;
      found = 1'b0;
      for (int i = `ACB_NUM_INPUTS - 1; i >= 0; i--)
      begin
         if (list[i] && (5'(i) >= start))
         begin
            hit = 4'(i);
            found = 1'b1;
         end
      end
      if (!found)
      begin
         for (int i = `ACB_NUM_INPUTS - 1; i >= 0; i--)
         begin
            if (list[i])
            begin
               hit = 4'(i);
            end
         end
      end
      return hit;
   endfunction

   // Byte-lane merge of a 16-bit register
   function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                              input logic [3:0] be, input logic [15:0] mask);
      logic [15:0] v;
      v = old;
      if (be[0])
      begin
         v[7:0] = wd[7:0];
      end
      if (be[1])
      begin
         v[15:8] = wd[15:8];
      end
      return v & mask;
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   logic [15:0] ctrl2_reg;
   logic [15:0] ctrl3_reg;
   logic [15:0] ctrl4_reg;
   logic [15:0] chs123_reg;
   logic [15:0] chs0_reg;
   logic [15:0] scan_reg;
   logic [15:0] pin_config_bits_reg;
   logic [15:0] mode_reg;
   logic waitrequest_reg;
   logic [31:0] readdata_reg;
   logic [31:0] readdata_next;
   logic wr_take;

   assign wr_take = write && !waitrequest_reg;

   // Field views
   logic res12;
   logic scan_en;
   logic split_mode;
   logic alt_mode;
   logic [3:0] rate;
   logic [2:0] trig;
   logic mod_off;
   logic half_reg;

   assign res12 = mode_reg[`ACB_MD_RES];
   assign trig = mode_reg[`ACB_MD_TRIG_HI:`ACB_MD_TRIG_LO];
   assign mod_off = mode_reg[`ACB_MD_DISABLE];
   assign scan_en = ctrl2_reg[`ACB_C2_SCAN_EN];
   assign split_mode = ctrl2_reg[`ACB_C2_SPLIT];
   assign alt_mode = ctrl2_reg[`ACB_C2_ALT];
   assign rate = ctrl2_reg[`ACB_C2_RATE_HI:`ACB_C2_RATE_LO];

   // ****************************************
   // Avalon handshake
   // ****************************************
   // One wait state keeps readdata a flop output
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         waitrequest_reg <= 1'b1;
      end
      else if ((read || write) && waitrequest_reg)
      begin
         waitrequest_reg <= 1'b0;
      end
      else
      begin
         waitrequest_reg <= 1'b1;
      end
   end

   always_comb
   begin
      readdata_next = 32'h0000_0000;
      unique case (address)
         `ACB_OFF_CTRL2:
         begin
            readdata_next[15:0] = ctrl2_reg;
            readdata_next[`ACB_C2_HALF] = half_reg;
            if (res12)
            begin
               readdata_next[`ACB_C2_CHUSED_HI:`ACB_C2_CHUSED_LO] = 2'h0;
            end
         end
         `ACB_OFF_CTRL3: readdata_next[15:0] = ctrl3_reg;
         `ACB_OFF_CTRL4: readdata_next[15:0] = ctrl4_reg;
         `ACB_OFF_CHS123: readdata_next[15:0] = res12 ? 16'h0000 : chs123_reg;
         `ACB_OFF_CHS0: readdata_next[15:0] = chs0_reg;
         `ACB_OFF_SCAN: readdata_next[15:0] = scan_reg;
         `ACB_OFF_PIN_CONFIG_BITS: readdata_next[15:0] = pin_config_bits_reg;
         `ACB_OFF_MODE: readdata_next[15:0] = mode_reg;
         default: readdata_next = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         readdata_reg <= 32'h0000_0000;
      end
      else if (read && waitrequest_reg)
      begin
         readdata_reg <= readdata_next;
      end
   end

   // ****************************************
   // Register writes
   // ****************************************
   // Half status bit is not stored here; the mask drops it
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl2_reg <= `ACB_RESET_VAL;
         ctrl3_reg <= `ACB_RESET_VAL;
         ctrl4_reg <= `ACB_RESET_VAL;
         chs123_reg <= `ACB_RESET_VAL;
         chs0_reg <= `ACB_RESET_VAL;
         scan_reg <= `ACB_RESET_VAL;
         pin_config_bits_reg <= `ACB_RESET_VAL;
         mode_reg <= `ACB_RESET_VAL;
      end
      else if (wr_take)
      begin
         unique case (address)
            `ACB_OFF_CTRL2: ctrl2_reg <= lane_merge(ctrl2_reg, writedata, byteenable,
                                                    `ACB_MASK_CTRL2);
            `ACB_OFF_CTRL3: ctrl3_reg <= lane_merge(ctrl3_reg, writedata, byteenable,
                                                    `ACB_MASK_CTRL3);
            `ACB_OFF_CTRL4: ctrl4_reg <= lane_merge(ctrl4_reg, writedata, byteenable,
                                                    `ACB_MASK_CTRL4);
            `ACB_OFF_CHS123: chs123_reg <= lane_merge(chs123_reg, writedata, byteenable,
                                                      `ACB_MASK_CHS123);
            `ACB_OFF_CHS0: chs0_reg <= lane_merge(chs0_reg, writedata, byteenable,
                                                  `ACB_MASK_CHS0);
            // All list bits stay writable even without a pin
            `ACB_OFF_SCAN: scan_reg <= lane_merge(scan_reg, writedata, byteenable,
                                                  `ACB_MASK_SCAN);
            `ACB_OFF_PIN_CONFIG_BITS: pin_config_bits_reg <= lane_merge(pin_config_bits_reg, writedata, byteenable,
                                                  `ACB_MASK_PIN_CONFIG_BITS);
            `ACB_OFF_MODE: mode_reg <= lane_merge(mode_reg, writedata, byteenable,
                                                  `ACB_MASK_MODE);
            default: ;
         endcase
      end
   end

   // ****************************************
   // Sample alternation and scan
   // ****************************************
   logic sample_b_reg;
   logic [3:0] scan_idx_reg;
   logic [3:0] scan_cur;

   assign scan_cur = scan_pick(scan_reg[12:0], {1'b0, scan_idx_reg});

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sample_b_reg <= 1'b0;
      end
      else if (!alt_mode)
      begin
         sample_b_reg <= 1'b0;
      end
      else if (conv_done)
      begin
         sample_b_reg <= !sample_b_reg;
      end
   end

   // Advance only after a Sample A conversion
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scan_idx_reg <= 4'h0;
      end
      else if (!scan_en)
      begin
         scan_idx_reg <= 4'h0;
      end
      else if (conv_done && !sample_b_reg)
      begin
         scan_idx_reg <= scan_pick(scan_reg[12:0], 5'(scan_cur) + 5'h01);
      end
   end

   // ****************************************
   // Increment rate and buffer half
   // ****************************************
   logic [3:0] rate_cnt_reg;
   logic dma_advance_reg;

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rate_cnt_reg <= 4'h0;
         dma_advance_reg <= 1'b0;
      end
      else if (conv_done && (rate_cnt_reg >= rate))
      begin
         rate_cnt_reg <= 4'h0;
         dma_advance_reg <= 1'b1;
      end
      else if (conv_done)
      begin
         rate_cnt_reg <= rate_cnt_reg + 4'h1;
         dma_advance_reg <= 1'b0;
      end
      else
      begin
         dma_advance_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         half_reg <= 1'b0;
      end
      else if (!split_mode)
      begin
         half_reg <= 1'b0;
      end
      else if (conv_done && (rate_cnt_reg >= rate))
      begin
         half_reg <= !half_reg;
      end
   end

   // ****************************************
   // Conversion clock
   // ****************************************
   logic rc_s1_reg;
   logic rc_s2_reg;
   logic rc_s3_reg;
   logic [7:0] div_cnt_reg;
   logic [7:0] div_eff;
   logic tick_reg;

   // Reserved divider codes clamp to the longest legal period
   assign div_eff = (ctrl3_reg[`ACB_C3_DIV_HI:`ACB_C3_DIV_LO] > `ACB_DIV_MAX) ?
                    `ACB_DIV_MAX : ctrl3_reg[`ACB_C3_DIV_HI:`ACB_C3_DIV_LO];

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rc_s1_reg <= 1'b0;
         rc_s2_reg <= 1'b0;
         rc_s3_reg <= 1'b0;
      end
      else
      begin
         rc_s1_reg <= rc_clock_in;
         rc_s2_reg <= rc_s1_reg;
         rc_s3_reg <= rc_s2_reg;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         div_cnt_reg <= 8'h00;
         tick_reg <= 1'b0;
      end
      else if (mod_off)
      begin
         div_cnt_reg <= 8'h00;
         tick_reg <= 1'b0;
      end
      else if (ctrl3_reg[`ACB_C3_RC])
      begin
         div_cnt_reg <= 8'h00;
         tick_reg <= rc_s2_reg && !rc_s3_reg;
      end
      else if (div_cnt_reg >= div_eff)
      begin
         div_cnt_reg <= 8'h00;
         tick_reg <= 1'b1;
      end
      else
      begin
         div_cnt_reg <= div_cnt_reg + 8'h01;
         tick_reg <= 1'b0;
      end
   end

   // ****************************************
   // Selection outputs
   // ****************************************
   acb_sel_t sel_reg;
   acb_sel_t sel_next;
   acb_buf_t buf_reg;
   acb_buf_t buf_next;
   logic [12:0] pin_digital_reg;
   logic [12:0] mux_ground_reg;

   always_comb
   begin
      sel_next = '0;
      sel_next.sample_b = sample_b_reg;
      if (sample_b_reg)
      begin
         sel_next.zero_pos = chs0_reg[12:8];
         sel_next.zero_neg = chs0_reg[15];
         sel_next.ch_1_3_pos = chs123_reg[8];
         sel_next.ch_1_3_neg = chs123_reg[10:9];
      end
      else
      begin
         sel_next.zero_pos = scan_en ? 5'(scan_cur) : chs0_reg[4:0];
         sel_next.zero_neg = chs0_reg[7];
         sel_next.ch_1_3_pos = chs123_reg[0];
         sel_next.ch_1_3_neg = chs123_reg[2:1];
      end
      // Codes above the last input or without a pin take the reference
      sel_next.zero_pos_vref_neg = (sel_next.zero_pos > `ACB_POS_MAX) ||
                                   !PIN_PRESENT[sel_next.zero_pos[3:0]];
      sel_next.channels_used = ctrl2_reg[`ACB_C2_CHUSED_HI:`ACB_C2_CHUSED_LO];
      if (res12)
      begin
         sel_next.channels_used = 2'h0;
         sel_next.ch_1_3_pos = 1'b0;
         sel_next.ch_1_3_neg = 2'h0;
      end
   end

   always_comb
   begin
      buf_next = '0;
      buf_next.start_addr = half_reg ? `ACB_HALF_UPPER : `ACB_HALF_LOWER;
      buf_next.words_per_input = 8'h01 << ctrl4_reg[2:0];
      buf_next.auto_sample_on = (trig == `ACB_TRIG_AUTO);
      buf_next.auto_sample_time = buf_next.auto_sample_on ?
                                  ctrl3_reg[`ACB_C3_SAMT_HI:`ACB_C3_SAMT_LO] : 5'h00;
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sel_reg <= '0;
         buf_reg <= '0;
      end
      else
      begin
         sel_reg <= sel_next;
         buf_reg <= buf_next;
      end
   end

   // A disabled module hands every pin back to the port logic
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_digital_reg <= 13'h0000;
         mux_ground_reg <= 13'h0000;
      end
      else if (mod_off)
      begin
         pin_digital_reg <= 13'h1fff;
         mux_ground_reg <= 13'h0000;
      end
      else
      begin
         pin_digital_reg <= pin_config_bits_reg[12:0];
         mux_ground_reg <= pin_config_bits_reg[12:0];
      end
   end

   // ****************************************
   // Output drive
   // ****************************************
   assign readdata = readdata_reg;
   assign waitrequest = waitrequest_reg;
   assign conv_clk_tick = tick_reg;
   assign sel = sel_reg;
   assign buf_cfg = buf_reg;
   assign dma_advance = dma_advance_reg;
   assign pin_digital = pin_digital_reg;
   assign mux_ground = mux_ground_reg;

endmodule

`default_nettype wire

/* testbench/acb_checker_sva.sv */
// Purpose: Port relations of the channel buffer control
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Bound to the top module at the foot of this file
`timescale 1ns/1ns
`default_nettype none
module acb_checker_sva
   import acb_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register bus
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   // Converter side
   input wire logic conv_done,
   input wire acb_sel_t sel,
   input wire acb_buf_t buf_cfg,
   input wire logic dma_advance,
   input wire logic [12:0] pin_digital,
   input wire logic [12:0] mux_ground
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   // ****************************************
   // Bus timing
   // ****************************************
   one_wait_a: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("request not answered after one wait state");
   idle_wait_a: assert property (!read && !write |=> waitrequest)
      else $error("answer without a request");
   upper_zero_a: assert property (!waitrequest |-> readdata[31:16] == 16'h0000)
      else $error("upper read lanes not zero");

   // ****************************************
   // Converter side
   // ****************************************
   advance_cause_a: assert property (dma_advance |-> $past(conv_done))
      else $error("advance without a completed conversion");
   start_move_a: assert property ($changed(buf_cfg.start_addr) |->
      $past(dma_advance) || $past(write, 2))
      else $error("fill start moved without an advance");
   start_value_a: assert property (buf_cfg.start_addr == 4'h0 || buf_cfg.start_addr == 4'h8)
      else $error("fill start not 0 or 8");
   sample_b_rise_a: assert property ($rose(sel.sample_b) |-> $past(conv_done, 2))
      else $error("sample B entered without a conversion");
   words_pow_a: assert property ($past(resetn) |-> $onehot(buf_cfg.words_per_input))
      else $error("buffer words not a power of two");
   absent_ref_a: assert property (sel.zero_pos > 5'h0c |-> sel.zero_pos_vref_neg)
      else $error("missing input not sent to reference");
   ground_pin_a: assert property ((mux_ground & ~pin_digital) == 13'h0000)
      else $error("mux grounded on an analog pin");

   adv_c: cover property (dma_advance);
   alt_c: cover property ($rose(sel.sample_b));
   read_c: cover property (read && !waitrequest);
endmodule

bind acb_channel_buffer_control acb_checker_sva chk (.clk(clk), .resetn(resetn), .read(read),
   .write(write), .readdata(readdata), .waitrequest(waitrequest), .conv_done(conv_done),
   .sel(sel), .buf_cfg(buf_cfg), .dma_advance(dma_advance), .pin_digital(pin_digital),
   .mux_ground(mux_ground));
`default_nettype wire

/* testbench/acb_far_model.sv */
// Purpose: Converter and DMA side seen by the control block
// Assumes: Completion pulses on clk; RC clock free of clk phase
// Notes: RC clock stands still unless rc_run is high
`timescale 1ns/1ns
`default_nettype none
module acb_far_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Events
   input wire logic dma_advance,
   input wire logic rc_run,
   output logic conv_done,
   output logic rc_clock_in
);
   int adv_count;
   int rc_rises;

   initial
   begin
      conv_done = 1'b0;
      rc_clock_in = 1'b0;
      adv_count = 0;
      rc_rises = 0;
   end

   // Counted on the settled half to avoid edge races
   always @(negedge clk)
      if (resetn && dma_advance)
         adv_count++;

   always #172
      if (rc_run)
         rc_clock_in = ~rc_clock_in;

   always @(posedge rc_clock_in)
      rc_rises++;

   // Gap 0 gives completions on consecutive edges
   task automatic convert(input int n, input int gap);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         conv_done <= 1'b1;
         if (gap > 0)
         begin
            @(posedge clk);
            conv_done <= 1'b0;
            repeat (gap - 1) @(posedge clk);
         end
      end
      @(posedge clk);
      conv_done <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* testbench/acb_channel_buffer_control_tb.sv */
// Purpose: Self-checking bench of the channel buffer control
// Assumes: 10 MHz clock, one wait state per bus access
// Notes: Expected values come from masks and field encodings
`timescale 1ns/1ns
`default_nettype none
`include "acb_consts.svh"
module acb_channel_buffer_control_tb
   import acb_pkg::*;
;
   logic clk;
   logic resetn;
   logic [5:0] address;
   logic read;
   logic write;
   logic [3:0] byteenable;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic waitrequest;
   logic conv_done;
   logic rc_clock_in;
   logic rc_run;
   logic conv_clk_tick;
   acb_sel_t sel;
   acb_buf_t buf_cfg;
   logic dma_advance;
   logic [12:0] pin_digital;
   logic [12:0] mux_ground;
   int bad_count;
   int check_count;
   int cycles;
   int tick_cnt;

   acb_channel_buffer_control dut (.clk(clk), .resetn(resetn), .address(address), .read(read),
      .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .conv_done(conv_done), .rc_clock_in(rc_clock_in),
      .conv_clk_tick(conv_clk_tick), .sel(sel), .buf_cfg(buf_cfg), .dma_advance(dma_advance),
      .pin_digital(pin_digital), .mux_ground(mux_ground));

   acb_far_model far (.clk(clk), .resetn(resetn), .dma_advance(dma_advance), .rc_run(rc_run),
      .conv_done(conv_done), .rc_clock_in(rc_clock_in));

   always #50 clk = ~clk;

   always @(negedge clk)
      if (conv_clk_tick)
         tick_cnt++;

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         bad_count++;
         end_sim;
      end
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // Request held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d,
      input logic [3:0] be, output logic [15:0] q);
      @(posedge clk);
      address <= a;
      writedata <= {16'h0000, d};
      byteenable <= be;
      read <= !wr;
      write <= wr;
      do
         @(posedge clk);
      while (waitrequest !== 1'b0);
      q = readdata[15:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, a, d, 4'hf, q);
   endtask

   task automatic rd_chk(input string what, input logic [5:0] a, input logic [15:0] exp);
      logic [15:0] q;
      bus(1'b0, a, 16'h0000, 4'hf, q);
      check(what, q, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic s_regs;
      logic [5:0] offs [8] = '{`ACB_OFF_CTRL2, `ACB_OFF_CTRL3, `ACB_OFF_CTRL4,
         `ACB_OFF_CHS123, `ACB_OFF_CHS0, `ACB_OFF_SCAN, `ACB_OFF_PIN_CONFIG_BITS, `ACB_OFF_MODE};
      logic [15:0] masks [8] = '{`ACB_MASK_CTRL2, `ACB_MASK_CTRL3, `ACB_MASK_CTRL4,
         `ACB_MASK_CHS123, `ACB_MASK_CHS0, `ACB_MASK_SCAN, `ACB_MASK_PIN_CONFIG_BITS, `ACB_MASK_MODE};
      for (int i = 0; i < 8; i++)
         rd_chk("reset value", offs[i], `ACB_RESET_VAL);
      for (int i = 0; i < 8; i++)
      begin
         wr(offs[i], 16'hffff);
         rd_chk("writable bits", offs[i], masks[i]);
      end
      for (int i = 7; i >= 0; i--)
         wr(offs[i], 16'h0000);
      wr(6'h20, 16'hffff);
      rd_chk("unmapped", 6'h20, 16'h0000);
      bus(1'b1, `ACB_OFF_CTRL4, 16'h0005, 4'h2, masks[0]);
      rd_chk("lane kept", `ACB_OFF_CTRL4, 16'h0000);
      wr(`ACB_OFF_CTRL4, 16'h0007);
      cyc(3);
      check("words per input", buf_cfg.words_per_input, 32'd128);
      wr(`ACB_OFF_CTRL4, 16'h0000);
   endtask

   task automatic s_rate;
      int a0;
      a0 = far.adv_count;
      wr(`ACB_OFF_CTRL2, 16'h000e);
      far.convert(4, 0);
      cyc(4);
      check("start upper", buf_cfg.start_addr, `ACB_HALF_UPPER);
      rd_chk("half status", `ACB_OFF_CTRL2, 16'h008e);
      far.convert(4, 3);
      cyc(4);
      check("start lower", buf_cfg.start_addr, `ACB_HALF_LOWER);
      check("advances", far.adv_count - a0, 2);
   endtask

   task automatic s_alt;
      wr(`ACB_OFF_CHS0, 16'h8503);
      wr(`ACB_OFF_CTRL2, 16'h0001);
      cyc(3);
      check("pos a", sel.zero_pos, 32'd3);
      far.convert(1, 1);
      cyc(3);
      check("sample b", sel.sample_b, 1);
      check("pos b", sel.zero_pos, 32'd5);
      check("neg b", sel.zero_neg, 1);
      far.convert(1, 1);
      cyc(3);
      check("back to a", sel.sample_b, 0);
   endtask

   task automatic s_scan;
      wr(`ACB_OFF_SCAN, 16'h0204);
      wr(`ACB_OFF_CTRL2, 16'h0400);
      cyc(3);
      check("scan first", sel.zero_pos, 32'd2);
      far.convert(1, 1);
      cyc(3);
      check("scan next", sel.zero_pos, 32'd9);
      far.convert(1, 1);
      cyc(3);
      check("scan wrap", sel.zero_pos, 32'd2);
      wr(`ACB_OFF_CTRL2, 16'h0000);
   endtask

   task automatic s_pins;
      wr(`ACB_OFF_PIN_CONFIG_BITS, 16'h0005);
      cyc(3);
      check("digital pins", pin_digital, 32'h0005);
      check("grounded mux", mux_ground, 32'h0005);
      wr(`ACB_OFF_MODE, 16'h0010);
      cyc(3);
      check("disabled pins", pin_digital, 32'h1fff);
      check("disabled mux", mux_ground, 32'h0000);
      wr(`ACB_OFF_MODE, 16'h0000);
   endtask

   task automatic s_res;
      wr(`ACB_OFF_MODE, 16'h0001);
      wr(`ACB_OFF_CTRL2, 16'h0300);
      rd_chk("used in 12-bit", `ACB_OFF_CTRL2, 16'h0000);
      wr(`ACB_OFF_CHS123, 16'h0007);
      rd_chk("chs123 in 12-bit", `ACB_OFF_CHS123, 16'h0000);
      wr(`ACB_OFF_MODE, 16'h0000);
      rd_chk("chs123 kept", `ACB_OFF_CHS123, 16'h0007);
      wr(`ACB_OFF_CHS0, 16'h000d);
      cyc(3);
      check("vref", sel.zero_pos_vref_neg, 1);
      check("used out", sel.channels_used, 32'h3);
      check("ch13 neg", sel.ch_1_3_neg, 32'h3);
      check("ch13 pos", sel.ch_1_3_pos, 1);
      wr(`ACB_OFF_CHS123, 16'h0000);
      wr(`ACB_OFF_CTRL2, 16'h0000);
   endtask

   task automatic s_clk;
      int t0;
      int r0;
      wr(`ACB_OFF_CTRL3, 16'h1f02);
      cyc(5);
      t0 = tick_cnt;
      cyc(30);
      check("divided ticks", tick_cnt - t0, 10);
      check("samt off", buf_cfg.auto_sample_time, 0);
      wr(`ACB_OFF_MODE, 16'h000e);
      wr(`ACB_OFF_CTRL3, 16'h9f00);
      cyc(6);
      t0 = tick_cnt;
      cyc(20);
      check("rc still", tick_cnt - t0, 0);
      r0 = far.rc_rises;
      rc_run <= 1'b1;
      cyc(30);
      rc_run <= 1'b0;
      cyc(8);
      check("rc ticks", tick_cnt - t0, far.rc_rises - r0);
      check("samt on", buf_cfg.auto_sample_time, 31);
      wr(`ACB_OFF_CTRL3, 16'h0000);
   endtask

   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      address = 6'h00;
      read = 1'b0;
      write = 1'b0;
      byteenable = 4'h0;
      writedata = 32'h0000_0000;
      rc_run = 1'b0;
      bad_count = 0;
      check_count = 0;
      cycles = 0;
      tick_cnt = 0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      s_regs;
      s_rate;
      s_alt;
      s_scan;
      s_pins;
      s_res;
      s_clk;
      end_sim;
   end
endmodule
`default_nettype wire
